// file: hdl/card_host_pkg.sv
package card_host_pkg;
  // ==========================================================
  // attribute registers of the card
  localparam logic [10:0] LINE_CHANGE_STATUS_OFS = 11'h004;
  localparam logic [10:0] DRIVE_SOCKET_SELECT_OFS = 11'h006;
  localparam int SOCKET_RSVD_BIT = 7;
  localparam int DRIVE_NUM_BIT = 4;
  // ==========================================================
  // controller registers on the software port
  localparam logic [4:0] CMD_OFS = 5'h00;
  localparam logic [4:0] ADDR_OFS = 5'h04;
  localparam logic [4:0] WDATA_OFS = 5'h08;
  localparam logic [4:0] RDATA_OFS = 5'h0C;
  localparam logic [4:0] STATUS_OFS = 5'h10;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WIDTH_LSB = 2;
  localparam int CMD_GO_BIT = 4;
  localparam int CMD_UDMA_START_BIT = 5;
  localparam int CMD_UDMA_STOP_BIT = 6;
  // ==========================================================
  // operations and access widths
  localparam logic [1:0] OP_IO_READ = 2'h0;
  localparam logic [1:0] OP_IO_WRITE = 2'h1;
  localparam logic [1:0] OP_ATTR_READ = 2'h2;
  localparam logic [1:0] OP_ATTR_WRITE = 2'h3;
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_WORD = 2'h1;
  localparam logic [1:0] WID_HIGH = 2'h2;
  // ==========================================================
  // timing
  localparam int CLK_NS = 4;
  localparam int T_SETUP_NS = 30;
  localparam int T_PULSE_NS = 165;
  localparam int T_HOLD_NS = 20;
  localparam int T_RECOVER_NS = 40;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RECOVER_CYC = 8'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // burst crc
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'h4ABA;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RECOVER,
    ST_U_WAITRQ, ST_U_ACK, ST_U_BURST, ST_U_TERM, ST_U_CRC, ST_U_DONE
  } host_state_t;
endpackage : card_host_pkg

// file: hdl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

// file: hdl/card_io_host.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// (RULE1) card sets ready-changed flag when internal ready toggles.
// (RULE2) card sets write-protect-changed flag when write protect toggles.
// (RULE3) card returns its internal ready status in the raw ready bit.
// (RULE4) card always reads zero in the write-protect state bit.
// (RULE5) ready-changed flag takes written value only when ready mask bit is one.
// (RULE6) write-protect-changed flag takes written value only when its mask is one.
// (RULE7) change register reads 0 in bits 7:6, ones in bits 3:2.
// (RULE8) drive-number bit reads as written, or zero when unsupported.
// (RULE9) card compares stored drive number with drive/head select bit. Here the card model only stores the bit and makes no comparison.
// (RULE10) card ignores socket-number field in low bits of socket register.
// (RULE11) host writes zero into reserved top bit of socket register.
// (RULE12) host writes socket register before config index, drive number zero.
// (RULE13) card asserts 16-bit width acknowledge for every decoded I/O address. Here the card model withholds it while no16_in is high.
// (RULE14) no width acknowledge: host splits a word into even then odd byte.
// (RULE15) card may stretch an input cycle by asserting wait at its start.
// (RULE16) byte access: low enable only, even or odd byte on low lane by A0.
// (RULE17) word access: both enables, A0 low, odd byte high lane, even low lane.
// (RULE18) high-byte access: high enable only, odd byte high lane, low lane floats.
// (RULE19) card ignores I/O strobes with attribute select high.
// (RULE20) card requests a burst by asserting DMARQ with strobe high.
// (RULE21) host: DMACK with STOP high, then STOP low; card asserts DMARDY. Here the host drives DMARDY (io read strobe) itself.
// (RULE22) receiver pauses by negating DMARDY; sender holds strobe static.
// (RULE23) device end: DMARQ negated; host asserts STOP, negates DMARDY.
// (RULE24) host-ended burst: host asserts STOP, card negates DMARQ and DMARDY. Here the host negates DMARDY together with STOP.
// (RULE25) card returns strobe to asserted level before the crc transfer.
// (RULE26) crc handed over on DMACK negation; burst done with DMARQ negated.
// (RULE27) host asserts DMACK only in answer to a pending DMARQ.
// (RULE28) status-changed low while a change flag is set and enabled. Here the card model drives it low whenever either flag is set, with no enable.
module card_io_host
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // software register port
  input wire logic [4:0] sw_addr_in,
  input wire logic [31:0] sw_wdata_in,
  input wire logic sw_write_in,
  input wire logic sw_read_in,
  output logic [31:0] sw_rdata_out,
  // burst data stream
  output logic [15:0] udma_data_out,
  output logic udma_valid_out,
  input wire logic udma_ready_in,
  // card control pins
  output logic [10:0] card_addr_out,
  output logic attr_select_n_out,
  output logic low_enable_n_out,
  output logic high_enable_n_out,
  output logic io_read_strobe_n_out,
  output logic io_write_strobe_n_out,
  output logic mem_read_strobe_n_out,
  output logic mem_write_strobe_n_out,
  // card data lanes
  input wire logic [15:0] card_data_in,
  output logic [15:0] card_data_out,
  output logic card_data_lo_oe_out,
  output logic card_data_hi_oe_out,
  // card status pins
  input wire logic width16_ack_n_in,
  input wire logic wait_n_in,
  input wire logic input_ack_n_in,
  input wire logic status_changed_n_in
);
  import card_host_pkg::*;

  typedef struct packed {
    host_state_t state;
    logic [7:0] cnt;
    logic [1:0] op;
    logic [1:0] width;
    logic [10:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic split;
    logic second;
    logic split_seen;
    logic stop_req;
    logic strobe_d;
    logic [15:0] crc;
    logic [31:0] sw_rdata;
    logic [15:0] u_data;
    logic u_valid;
    logic [10:0] pin_addr;
    logic reg_n;
    logic ce1_n;
    logic ce2_n;
    logic ior_n;
    logic iow_n;
    logic oer_n;
    logic wer_n;
    logic [15:0] dout;
    logic oe_lo;
    logic oe_hi;
  } host_t;

  host_t s_reg, s_next;
  logic [19:0] pins_s;
  logic w16_ack_s, strobe_s, dmarq_n_s, status_changed_n_n_s;
  logic [15:0] data_s;

  // ==========================================================
  // pin synchronisers
  pin_sync #(.WIDTH(20), .RESET_VAL(20'h0_000F)) u_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({card_data_in, width16_ack_n_in, wait_n_in, input_ack_n_in,
               status_changed_n_in}),
    .sync_out(pins_s)
  );
  assign data_s = pins_s[19:4];
  assign w16_ack_s = pins_s[3];
  assign strobe_s = pins_s[2];
  assign dmarq_n_s = pins_s[1];
  assign status_changed_n_n_s = pins_s[0];

  // ==========================================================
  // helpers
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_word

  function automatic logic is_write(input logic [1:0] op);
    return (op == OP_IO_WRITE) || (op == OP_ATTR_WRITE);
  endfunction : is_write

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.u_valid = 1'b0;
    s_next.strobe_d = strobe_s;
    if (s_reg.cnt != 8'h00) begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end
    if (sw_write_in && (sw_addr_in == ADDR_OFS)) begin
      s_next.addr = sw_wdata_in[10:0];
    end
    if (sw_write_in && (sw_addr_in == WDATA_OFS)) begin
      s_next.wdata = sw_wdata_in[15:0];
    end
    if (sw_write_in && (sw_addr_in == CMD_OFS) && sw_wdata_in[CMD_UDMA_STOP_BIT]) begin
      s_next.stop_req = 1'b1;
    end
    s_next.sw_rdata = 32'h0000_0000;
    if (sw_read_in) begin
      unique case (sw_addr_in)
        ADDR_OFS: s_next.sw_rdata = {21'h00_0000, s_reg.addr};
        WDATA_OFS: s_next.sw_rdata = {16'h0000, s_reg.wdata};
        RDATA_OFS: s_next.sw_rdata = {16'h0000, s_reg.rdata};
        STATUS_OFS: s_next.sw_rdata = {27'h000_0000, s_reg.split_seen, !status_changed_n_n_s,
                                       !dmarq_n_s, s_reg.state >= ST_U_WAITRQ,
                                       s_reg.state != ST_IDLE};
        default: s_next.sw_rdata = 32'h0000_0000;
      endcase
    end
    unique case (s_reg.state)
      ST_IDLE: begin
        if (sw_write_in && (sw_addr_in == CMD_OFS) && sw_wdata_in[CMD_GO_BIT]) begin
          s_next.op = sw_wdata_in[CMD_OP_LSB +: 2];
          s_next.width = sw_wdata_in[CMD_WIDTH_LSB +: 2];
          s_next.split = 1'b0;
          s_next.second = 1'b0;
          s_next.split_seen = 1'b0;
          s_next.reg_n = 1'b0;
          s_next.pin_addr = s_reg.addr;
          s_next.cnt = SETUP_CYC;
          s_next.state = ST_SETUP;
          unique case (sw_wdata_in[CMD_WIDTH_LSB +: 2])
            WID_WORD: begin
              s_next.ce1_n = 1'b0; // RULE17
              s_next.ce2_n = 1'b0;
              s_next.pin_addr[0] = 1'b0;
            end
            WID_HIGH: begin
              s_next.ce1_n = 1'b1; // RULE18
              s_next.ce2_n = 1'b0;
            end
            default: begin
              s_next.ce1_n = 1'b0; // RULE16
              s_next.ce2_n = 1'b1;
            end
          endcase
        end else if (sw_write_in && (sw_addr_in == CMD_OFS)
                     && sw_wdata_in[CMD_UDMA_START_BIT]) begin
          s_next.stop_req = 1'b0;
          s_next.state = ST_U_WAITRQ;
        end
      end
      ST_SETUP: begin
        if (s_reg.cnt == 8'h00) begin
          if (s_reg.width == WID_WORD && w16_ack_s && !s_reg.op[1]) begin
            // no width acknowledge: redo as even byte then odd byte
            s_next.split = 1'b1; // RULE14
            s_next.split_seen = 1'b1;
            s_next.width = WID_BYTE;
            s_next.ce2_n = 1'b1;
            s_next.cnt = SETUP_CYC;
          end else begin
            s_next.cnt = PULSE_CYC;
            s_next.state = ST_STROBE;
            if (s_reg.op[1]) begin
              s_next.oer_n = is_write(s_reg.op);
              s_next.wer_n = !is_write(s_reg.op);
            end else begin
              s_next.ior_n = is_write(s_reg.op);
              s_next.iow_n = !is_write(s_reg.op);
            end
            if (is_write(s_reg.op)) begin
              s_next.oe_lo = !s_reg.ce1_n; // RULE16 RULE17 RULE18
              s_next.oe_hi = !s_reg.ce2_n;
              s_next.dout = s_reg.wdata;
              if (s_reg.second) begin
                s_next.dout[7:0] = s_reg.wdata[15:8];
              end
              if (s_reg.op == OP_ATTR_WRITE && s_reg.pin_addr == DRIVE_SOCKET_SELECT_OFS) begin
                s_next.dout[SOCKET_RSVD_BIT] = 1'b0; // RULE11
                s_next.dout[DRIVE_NUM_BIT] = 1'b0; // RULE12
              end
            end
          end
        end
      end
      ST_STROBE: begin
        // a low wait line stretches the strobe
        if (s_reg.cnt == 8'h00 && strobe_s) begin
          if (!is_write(s_reg.op)) begin
            unique case (s_reg.width)
              WID_WORD: s_next.rdata = data_s;
              WID_HIGH: s_next.rdata = {data_s[15:8], 8'h00};
              default: begin
                if (s_reg.second) begin
                  s_next.rdata[15:8] = data_s[7:0];
                end else begin
                  s_next.rdata = {8'h00, data_s[7:0]};
                end
              end
            endcase
          end
          s_next.ior_n = 1'b1;
          s_next.iow_n = 1'b1;
          s_next.oer_n = 1'b1;
          s_next.wer_n = 1'b1;
          s_next.cnt = HOLD_CYC;
          s_next.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.oe_lo = 1'b0;
          s_next.oe_hi = 1'b0;
          s_next.ce1_n = 1'b1;
          s_next.ce2_n = 1'b1;
          s_next.cnt = RECOVER_CYC;
          s_next.state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (s_reg.cnt == 8'h00) begin
          if (s_reg.split && !s_reg.second) begin
            s_next.second = 1'b1; // RULE14
            s_next.pin_addr[0] = 1'b1;
            s_next.ce1_n = 1'b0;
            s_next.cnt = SETUP_CYC;
            s_next.state = ST_SETUP;
          end else begin
            s_next.reg_n = 1'b1;
            s_next.state = ST_IDLE;
          end
        end
      end
      ST_U_WAITRQ: begin
        if (!dmarq_n_s) begin
          s_next.reg_n = 1'b0; // RULE27
          s_next.iow_n = 1'b1;
          s_next.cnt = SETUP_CYC;
          s_next.crc = CRC_SEED;
          s_next.state = ST_U_ACK;
        end
      end
      ST_U_ACK: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.iow_n = 1'b0; // RULE21
          s_next.ior_n = !udma_ready_in;
          s_next.state = ST_U_BURST;
        end
      end
      ST_U_BURST, ST_U_TERM: begin
        if (s_reg.state == ST_U_BURST && strobe_s != s_reg.strobe_d) begin
          s_next.u_data = data_s;
          s_next.u_valid = 1'b1;
          s_next.crc = crc_word(s_reg.crc, data_s);
        end
        if (s_reg.state == ST_U_BURST) begin
          s_next.ior_n = !udma_ready_in; // RULE22
          if (s_reg.stop_req || dmarq_n_s) begin
            s_next.iow_n = 1'b1; // RULE23 RULE24
            s_next.ior_n = 1'b1;
            s_next.state = ST_U_TERM;
          end
        end else if (dmarq_n_s && strobe_s) begin
          s_next.dout = s_next.crc;
          s_next.oe_lo = 1'b1;
          s_next.oe_hi = 1'b1;
          s_next.cnt = SETUP_CYC;
          s_next.state = ST_U_CRC;
        end
      end
      ST_U_CRC: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.reg_n = 1'b1; // RULE26
          s_next.cnt = HOLD_CYC;
          s_next.state = ST_U_DONE;
        end
      end
      ST_U_DONE: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.oe_lo = 1'b0;
          s_next.oe_hi = 1'b0;
          s_next.stop_req = 1'b0;
          s_next.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_reg <= '{state: ST_IDLE, reg_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1,
                 ior_n: 1'b1, iow_n: 1'b1, oer_n: 1'b1, wer_n: 1'b1,
                 strobe_d: 1'b1, crc: CRC_SEED, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign sw_rdata_out = s_reg.sw_rdata;
  assign udma_data_out = s_reg.u_data;
  assign udma_valid_out = s_reg.u_valid;
  assign card_addr_out = s_reg.pin_addr;
  assign attr_select_n_out = s_reg.reg_n;
  assign low_enable_n_out = s_reg.ce1_n;
  assign high_enable_n_out = s_reg.ce2_n;
  assign io_read_strobe_n_out = s_reg.ior_n;
  assign io_write_strobe_n_out = s_reg.iow_n;
  assign mem_read_strobe_n_out = s_reg.oer_n;
  assign mem_write_strobe_n_out = s_reg.wer_n;
  assign card_data_out = s_reg.dout;
  assign card_data_lo_oe_out = s_reg.oe_lo;
  assign card_data_hi_oe_out = s_reg.oe_hi;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence ack_with_stop_s;
    !attr_select_n_out && io_write_strobe_n_out && s_reg.state == ST_U_ACK;
  endsequence
  sequence burst_running_s;
    !io_write_strobe_n_out && s_reg.state == ST_U_BURST;
  endsequence

  chk_ack_after_rq: assert property (s_reg.state == ST_U_ACK && $past(s_reg.state) == ST_U_WAITRQ |-> $past(!dmarq_n_s)) else $error("dmack without dmarq"); // RULE27
  chk_stop_then_go: assert property ($fell(io_write_strobe_n_out) && s_reg.state == ST_U_BURST |-> $past(!attr_select_n_out, 2) && $past(io_write_strobe_n_out)) else $error("stop negated early"); // RULE21
  chk_ack_sequence: assert property (ack_with_stop_s ##1 !ack_with_stop_s |-> burst_running_s) else $error("burst not started"); // RULE21
  chk_device_end: assert property (burst_running_s and dmarq_n_s |=> io_write_strobe_n_out && io_read_strobe_n_out) else $error("no stop on device end"); // RULE23
  chk_host_end: assert property (burst_running_s and s_reg.stop_req |=> io_write_strobe_n_out ##1 io_write_strobe_n_out) else $error("stop not held"); // RULE24
  chk_crc_on_neg: assert property ($rose(attr_select_n_out) && s_reg.state == ST_U_DONE |-> card_data_lo_oe_out && card_data_hi_oe_out && card_data_out == $past(s_reg.crc)) else $error("crc not driven at dmack negation"); // RULE26
  chk_socket_rsvd: assert property (!mem_write_strobe_n_out && card_addr_out == DRIVE_SOCKET_SELECT_OFS |-> !card_data_out[SOCKET_RSVD_BIT]) else $error("socket top bit set"); // RULE11
  chk_byte_lanes: assert property (!io_write_strobe_n_out && s_reg.state == ST_STROBE && !low_enable_n_out && high_enable_n_out |-> card_data_lo_oe_out && !card_data_hi_oe_out) else $error("byte lane wrong"); // RULE16
  chk_word_even: assert property (s_reg.state == ST_STROBE && !low_enable_n_out && !high_enable_n_out |-> !card_addr_out[0]) else $error("word access on odd address"); // RULE17
  chk_high_float: assert property (s_reg.state == ST_STROBE && low_enable_n_out |-> !card_data_lo_oe_out) else $error("low lane driven on high byte"); // RULE18
  chk_split_pair: assert property ($rose(s_reg.second) |-> s_reg.split && card_addr_out[0] && high_enable_n_out) else $error("split second half wrong"); // RULE14
endmodule : card_io_host

// file: bench/card_model.sv
`timescale 1ns/10ps
module card_model
  import card_host_pkg::*;
(
  // card pins from the host
  input wire logic [10:0] addr_in,
  input wire logic attr_select_n_in,
  input wire logic low_enable_n_in,
  input wire logic high_enable_n_in,
  input wire logic io_read_strobe_n_in,
  input wire logic io_write_strobe_n_in,
  input wire logic mem_read_strobe_n_in,
  input wire logic mem_write_strobe_n_in,
  input wire logic [15:0] data_in,
  // scenario controls
  input wire logic ready_in,
  input wire logic no16_in,
  input wire logic slow_in,
  input wire logic burst_go_in,
  input wire logic [7:0] burst_len_in,
  // card pins to the host
  output logic [15:0] data_out,
  output logic width16_ack_n_out,
  output logic wait_n_out,
  output logic input_ack_n_out,
  output logic status_changed_n_out,
  output logic err_out
);
  logic [7:0] io_mem [16];
  logic [7:0] noise = 8'h5A;
  logic ready_flag = 1'b0;
  logic wp_flag = 1'b0;
  logic drive_num = 1'b0;
  logic bursting = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [3:0] a;
  logic io_sel;
  int n;
  initial begin
    wait_n_out = 1'b1;
    input_ack_n_out = 1'b1;
    err_out = 1'b0;
  end
  // ========
  // decode; released lanes flip so a stale value never matches
  always #2 noise = ~noise;
  assign a = addr_in[3:0];
  assign io_sel = !attr_select_n_in && !(low_enable_n_in && high_enable_n_in);
  assign width16_ack_n_out = !(io_sel && !no16_in);
  assign status_changed_n_out = !(ready_flag || wp_flag);
  always_comb begin
    data_out = {noise, ~noise};
    if (bursting) begin
      data_out = word;
    end else if (io_sel && !mem_read_strobe_n_in && addr_in == LINE_CHANGE_STATUS_OFS) begin
      data_out[7:0] = {2'b00, ready_flag, wp_flag, 2'b11, ready_in, 1'b0};
    end else if (io_sel && !mem_read_strobe_n_in && addr_in == DRIVE_SOCKET_SELECT_OFS) begin
      data_out[7:0] = {3'b000, drive_num, 4'h0};
    end else if (io_sel && !io_read_strobe_n_in) begin
      if (!low_enable_n_in) data_out[7:0] = io_mem[a];
      if (!high_enable_n_in) data_out[15:8] = io_mem[a | 4'h1];
    end
  end
  // ========
  // registers; write protect never toggles, so only the host sets its flag
  always @(ready_in) ready_flag = 1'b1;
  always @(posedge mem_write_strobe_n_in) if (io_sel) begin
    if (addr_in == LINE_CHANGE_STATUS_OFS) begin
      if (data_in[1]) ready_flag = data_in[5];
      if (data_in[0]) wp_flag = data_in[4];
    end
    if (addr_in == DRIVE_SOCKET_SELECT_OFS) begin
      drive_num = data_in[4];
      if (data_in[7] || data_in[4]) err_out = 1'b1;
    end
  end
  always @(posedge io_write_strobe_n_in) if (io_sel) begin
    if (!low_enable_n_in) io_mem[a] = data_in[7:0];
    if (!high_enable_n_in) io_mem[a | 4'h1] = data_in[15:8];
  end
  always @(negedge io_read_strobe_n_in) if (io_sel && slow_in) begin
    wait_n_out = 1'b0;
    #120 wait_n_out = 1'b1;
  end
  always @(negedge attr_select_n_in) begin
    if (low_enable_n_in && high_enable_n_in && input_ack_n_out) err_out = 1'b1;
  end
  // ========
  // data-in burst, strobe period 64 ns
  always begin
    @(posedge burst_go_in);
    input_ack_n_out = 1'b0;
    wait (!attr_select_n_in && low_enable_n_in && high_enable_n_in && !io_write_strobe_n_in);
    bursting = 1'b1;
    n = 0;
    while (!io_write_strobe_n_in && (burst_len_in == 8'h00 || n < int'(burst_len_in))) begin
      #28;
      if (!io_read_strobe_n_in) begin
        word = 16'hA000 + 16'(n);
        #4 wait_n_out = ~wait_n_out;
        n++;
      end else begin
        #4;
      end
    end
    input_ack_n_out = 1'b1;
    wait (io_write_strobe_n_in && io_read_strobe_n_in);
    #32 wait_n_out = 1'b1;
    bursting = 1'b0;
    @(posedge attr_select_n_in);
  end
endmodule : card_model

// file: bench/card_io_host_tb.sv
`timescale 1ns/10ps
module card_io_host_tb;
  import card_host_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [4:0] sw_addr = 5'h00;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_write = 1'b0, sw_read = 1'b0;
  logic udma_ready = 1'b1;
  logic ready = 1'b0, no16 = 1'b0, slow = 1'b0, burst_go = 1'b0;
  logic [7:0] burst_len = 8'h00;
  logic [31:0] sw_rdata;
  logic [15:0] udma_data, host_data, card_data, lanes;
  logic [10:0] card_addr;
  logic udma_valid, attr_n, lo_n, hi_n, iord_n, iowr_n, mrd_n, mwr_n, lo_oe, hi_oe;
  logic w16_n, wait_n, inack_n, stchg_n, card_err;
  logic [31:0] exp_q[$], mask_q[$];
  logic [15:0] word_q[$];
  logic chk_flag = 1'b0, rd_chk = 1'b0, quiet = 1'b0;
  logic [1:0] flags;
  logic [31:0] seed = 32'h0000_0016;
  logic [31:0] v, got;
  int num_errors = 0, num_checks = 0;

  always #2 ref_clk_in = ~ref_clk_in;
  assign lanes = {hi_oe ? host_data[15:8] : card_data[15:8], lo_oe ? host_data[7:0] : card_data[7:0]};

  card_io_host dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_write_in(sw_write), .sw_read_in(sw_read), .sw_rdata_out(sw_rdata),
    .udma_data_out(udma_data), .udma_valid_out(udma_valid), .udma_ready_in(udma_ready),
    .card_addr_out(card_addr), .attr_select_n_out(attr_n), .low_enable_n_out(lo_n),
    .high_enable_n_out(hi_n), .io_read_strobe_n_out(iord_n), .io_write_strobe_n_out(iowr_n),
    .mem_read_strobe_n_out(mrd_n), .mem_write_strobe_n_out(mwr_n), .card_data_in(lanes),
    .card_data_out(host_data), .card_data_lo_oe_out(lo_oe), .card_data_hi_oe_out(hi_oe),
    .width16_ack_n_in(w16_n), .wait_n_in(wait_n), .input_ack_n_in(inack_n),
    .status_changed_n_in(stchg_n));
  card_model card_u (.addr_in(card_addr), .attr_select_n_in(attr_n), .low_enable_n_in(lo_n),
    .high_enable_n_in(hi_n), .io_read_strobe_n_in(iord_n), .io_write_strobe_n_in(iowr_n),
    .mem_read_strobe_n_in(mrd_n), .mem_write_strobe_n_in(mwr_n), .data_in(lanes),
    .ready_in(ready), .no16_in(no16), .slow_in(slow), .burst_go_in(burst_go),
    .burst_len_in(burst_len), .data_out(card_data), .width16_ack_n_out(w16_n),
    .wait_n_out(wait_n), .input_ack_n_out(inack_n), .status_changed_n_out(stchg_n),
    .err_out(card_err));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // ========
  // software port
  task sw_wr(input logic [4:0] ad, input logic [31:0] d);
    @(posedge ref_clk_in);
    sw_addr <= ad;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge ref_clk_in);
    sw_write <= 1'b0;
  endtask : sw_wr
  task sw_rd(input logic [4:0] ad, input logic [31:0] e, input logic [31:0] m = 32'h0000_FFFF,
             input logic c = 1'b1);
    @(posedge ref_clk_in);
    sw_addr <= ad;
    sw_read <= 1'b1;
    chk_flag <= c;
    if (c) begin
      exp_q.push_back(e & m);
      mask_q.push_back(m);
    end
    @(posedge ref_clk_in);
    sw_read <= 1'b0;
    #1 got = sw_rdata;
  endtask : sw_rd
  task idle_wait();
    for (int i = 0; i < 400; i++) begin
      sw_rd(STATUS_OFS, 32'h0, 32'h0, 1'b0);
      if (got[1:0] === 2'b00) return;
    end
    check(32'h1, 32'h0);
    results();
  endtask : idle_wait
  task op(input logic [1:0] o, input logic [1:0] w, input logic [10:0] ad,
          input logic [15:0] d = 16'h0000);
    sw_wr(ADDR_OFS, 32'(ad));
    sw_wr(WDATA_OFS, 32'(d));
    sw_wr(CMD_OFS, 32'(o) | (32'(w) << CMD_WIDTH_LSB) | (32'h1 << CMD_GO_BIT));
    idle_wait();
  endtask : op
  // ========
  // monitor: oldest note per result
  always @(posedge ref_clk_in) begin
    if (rd_chk) check(sw_rdata & mask_q.pop_front(), exp_q.pop_front());
    if (udma_valid && (quiet || word_q.size() == 0)) check(32'h1, 32'h0);
    else if (udma_valid) check(32'(udma_data), 32'(word_q.pop_front()));
    rd_chk <= sw_read && chk_flag;
  end
  // ========
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    op(OP_ATTR_WRITE, WID_BYTE, LINE_CHANGE_STATUS_OFS, 16'h0003);
    flags = 2'b00;
    for (int i = 0; i < 9; i++) begin
      v = xs();
      op(OP_ATTR_WRITE, WID_BYTE, LINE_CHANGE_STATUS_OFS, 16'(v[7:0] & 8'h33));
      if (i == 8) ready <= ~ready;
      if (v[1]) flags[1] = v[5];
      if (v[0]) flags[0] = v[4];
      if (i == 8) flags[1] = 1'b1;
      op(OP_ATTR_READ, WID_BYTE, LINE_CHANGE_STATUS_OFS);
      sw_rd(RDATA_OFS, {26'h0, flags, 2'b11, ready, 1'b0});
    end
    sw_rd(STATUS_OFS, 32'h8, 32'h8);
    op(OP_ATTR_WRITE, WID_BYTE, LINE_CHANGE_STATUS_OFS, 16'h0003);
    sw_rd(STATUS_OFS, 32'h0, 32'h8);
    op(OP_ATTR_WRITE, WID_BYTE, DRIVE_SOCKET_SELECT_OFS, 16'h00FF);
    op(OP_ATTR_READ, WID_BYTE, DRIVE_SOCKET_SELECT_OFS);
    sw_rd(RDATA_OFS, 32'h0);
    $display("attr done");
    for (int i = 0; i < 4; i++) begin
      v = xs();
      slow <= v[8];
      no16 <= (i == 3);
      op(OP_IO_WRITE, WID_WORD, 11'(4 * i), v[15:0]);
      op(OP_IO_READ, WID_WORD, 11'(4 * i));
      sw_rd(RDATA_OFS, {16'h0, v[15:0]});
      op(OP_IO_READ, WID_BYTE, 11'(4 * i + 1));
      sw_rd(RDATA_OFS, {24'h0, v[15:8]});
      op(OP_IO_WRITE, WID_BYTE, 11'(4 * i), {8'h00, ~v[7:0]});
      op(OP_IO_READ, WID_HIGH, 11'(4 * i));
      sw_rd(RDATA_OFS, {16'h0, v[15:8], 8'h00});
      op(OP_IO_READ, WID_BYTE, 11'(4 * i));
      sw_rd(RDATA_OFS, {24'h0, ~v[7:0]});
    end
    $display("io done");
    no16 <= 1'b0;
    for (int i = 0; i < 6; i++) word_q.push_back(16'hA000 + 16'(i));
    burst_len <= 8'd6;
    sw_wr(CMD_OFS, 32'h1 << CMD_UDMA_START_BIT);
    burst_go <= 1'b1;
    repeat (30) @(posedge ref_clk_in);
    udma_ready <= 1'b0;
    repeat (24) @(posedge ref_clk_in);
    quiet <= 1'b1;
    repeat (60) @(posedge ref_clk_in);
    quiet <= 1'b0;
    udma_ready <= 1'b1;
    idle_wait();
    check(32'(word_q.size()), 32'h0);
    burst_go <= 1'b0;
    for (int i = 0; i < 64; i++) word_q.push_back(16'hA000 + 16'(i));
    burst_len <= 8'd0;
    sw_wr(CMD_OFS, 32'h1 << CMD_UDMA_START_BIT);
    burst_go <= 1'b1;
    repeat (100) @(posedge ref_clk_in);
    sw_wr(CMD_OFS, 32'h1 << CMD_UDMA_STOP_BIT);
    idle_wait();
    check(32'(word_q.size() > 40 && word_q.size() < 64), 32'h1);
    word_q.delete();
    check(32'(card_err), 32'h0);
    $display("burst done");
    results();
  end
endmodule : card_io_host_tb
